// ### arp_dc_filter.sv
// per-channel high-pass filter by running dc estimate, with offset hold
`timescale 1ns/100ps
`include "arp_defs.svh"
module arp_dc_filter #(
    parameter int SW = `ARP_SAMPLE_W,
    parameter int SHIFT = `ARP_HPF_SHIFT
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_valid,
    input wire logic signed [SW-1:0] i_data,
    input wire logic i_hpf_en,
    input wire logic i_hold,
    output logic o_valid,
    output logic signed [SW-1:0] o_data
);
    localparam int AW = SW + SHIFT + 1;

    generate
        if (SHIFT < 1 || SHIFT > 20) begin : g_chk
            $error("filter shift out of range");
        end
    endgenerate

    logic signed [AW-1:0] acc_reg;
    wire signed [SW:0] est = acc_reg[AW-1:SHIFT];
    wire signed [SW+1:0] diff = {{2{i_data[SW-1]}}, i_data} - {est[SW], est};
    wire use_offset = i_hpf_en | i_hold;
    wire signed [SW-1:0] max_v = {1'b0, {(SW-1){1'b1}}};
    wire signed [SW-1:0] min_v = {1'b1, {(SW-1){1'b0}}};
    wire signed [SW-1:0] sat = (diff > $signed({{2{1'b0}}, max_v})) ? max_v :
                               (diff < $signed({{2{1'b1}}, min_v})) ? min_v : diff[SW-1:0];
    wire signed [AW-1:0] acc_step = acc_reg + {{(AW-SW-2){diff[SW+1]}}, diff};

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_reg <= '0;
            o_valid <= 1'b0;
            o_data <= '0;
        end else if (i_ce) begin
            o_valid <= i_valid;
            if (i_valid) begin
                o_data <= use_offset ? sat : i_data;
                if (i_hpf_en) begin
                    acc_reg <= acc_step;
                end else if (!i_hold) begin
                    acc_reg <= '0;
                end
                // held estimate is left untouched while the filter is off
            end
        end
    end
endmodule : arp_dc_filter

// ### arp_defs.svh
// register offsets, field positions, reset values and counts of the record path control
`ifndef ARP_DEFS_SVH
`define ARP_DEFS_SVH

`define ARP_ADDR_W 7
`define ARP_DATA_W 9
`define ARP_SAMPLE_W 24

`define ARP_REG_LEFT_PGA 7'h00
`define ARP_REG_RIGHT_PGA 7'h01
`define ARP_REG_PATH_CTRL 7'h05
`define ARP_REG_LEVEL_CTRL 7'h11
`define ARP_REG_LEFT_ADC_VOL 7'h15
`define ARP_REG_RIGHT_ADC_VOL 7'h16
`define ARP_REG_ADD_CTRL1 7'h17
`define ARP_REG_INPUT_PATH 7'h20

`define ARP_BIT_UPDATE 8
`define ARP_BIT_MUTE 7
`define ARP_BIT_ZC 6
`define ARP_PGA_GAIN_MSB 5
`define ARP_BIT_INVERT 5
`define ARP_BIT_HOLD 4
`define ARP_BIT_HPF_L 0
`define ARP_BIT_HPF_R 1
`define ARP_BIT_ALC 8
`define ARP_BIT_TIMEOUT 0
`define ARP_BIT_DIFF 8
`define ARP_BOOST_MSB 5
`define ARP_BOOST_LSB 4

`define ARP_PGA_GAIN_RST 6'h17
`define ARP_PGA_MUTE_RST 1'b1
`define ARP_ADC_VOL_RST 8'hC3
`define ARP_BOOST_RST 2'h0

`define ARP_VOL_EXP_BIAS 9'h009
`define ARP_VOL_STEPS_PER_6DB 9'h00C
`define ARP_VOL_FRAC_SHIFT 32

`define ARP_ZC_TIMEOUT_SMP 1024
`define ARP_HPF_SHIFT 10

`endif

// ### arp_gain_if.sv
// carrier between register logic and one channel's gain release logic
`timescale 1ns/100ps
interface arp_gain_if;
    logic req;
    arp_pkg::arp_pga_gain_t req_gain;
    logic req_mute;
    arp_pkg::arp_pga_gain_t gain;
    logic mute;
    modport ctrl (output req, output req_gain, output req_mute, input gain, input mute);
    modport zc (input req, input req_gain, input req_mute, output gain, output mute);
endinterface : arp_gain_if

// ### arp_host.sv
// host model driving the control register port
`timescale 1ns/100ps
module arp_host (
    input wire logic i_clk,
    input wire logic i_rvalid,
    input wire logic [8:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [6:0] o_addr,
    output logic [8:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 7'h7F;
        o_wdata = 9'h000;
    end
    // released lines show the inverse so stale values stand out
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [6:0] a, output logic [8:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rvalid ? i_rdata : 'x;
    endtask : rd
endmodule : arp_host

// ### arp_pkg.sv
// types shared by the record path control modules
package arp_pkg;
    typedef enum logic [0:0] {ARP_ZC_IDLE, ARP_ZC_WAIT} arp_zc_state_e;
    typedef logic [5:0] arp_pga_gain_t;
endpackage : arp_pkg

// ### arp_record_ctrl.sv
// record path control: registers, amplifier gain control and adc output datapath
// How it works
// - diff select clear feeds left input alone; set feeds left minus right.
// - mic boost code: 00 bypass, 01 13 dB, 10 20 dB, 11 29 dB.
// - amplifier code 63 is +30 dB, 0 is -17.25 dB, 0.75 dB steps, reset 0 dB.
// - left amplifier register writes ignored while level control owns that channel.
// - update clear only latches; update set applies written code and other latch together.
// - mute resets on; clearing mute needs the update bit, in the same write or a later one to either amplifier.
// - zero cross enabled defers amplifier changes to a crossing, else immediate.
// - with timeout enabled a waiting change is forced after the timeout.
// - high-pass on: dc estimated continuously and subtracted; off without hold: no filtering.
// - filter off with hold keeps subtracting last estimate; without hold clears it.
// - held estimate never changes while the filter stays off and hold stays set.
// - invert bit clear passes samples, set negates them.
// - adc volume code X gives 0.5*(X-195) dB, code 0 mutes.
// - left adc volume resets to 0xC3, 0 dB.
// - volume update clear only stores; either update applies both stored codes.
// - high-pass enabled separately per channel.
// - samples carried at full 24-bit width to the output.
// - left adc volume update sits at bit 8 above the code.
// - level control select decides which amplifier the automatic control owns; here set owns the left, clear owns neither.
`timescale 1ns/100ps
`include "arp_defs.svh"
module arp_record_ctrl #(
    parameter int SW = `ARP_SAMPLE_W,
    parameter int ZC_TIMEOUT = `ARP_ZC_TIMEOUT_SMP,
    parameter int HPF_SHIFT = `ARP_HPF_SHIFT
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [`ARP_ADDR_W-1:0] i_reg_addr,
    input wire logic [`ARP_DATA_W-1:0] i_reg_wdata,
    output logic [`ARP_DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_smp_valid,
    input wire logic [SW-1:0] i_smp_left,
    input wire logic [SW-1:0] i_smp_right,
    output logic o_smp_valid,
    output logic [SW-1:0] o_smp_left,
    output logic [SW-1:0] o_smp_right,
    output logic o_diff_input_select,
    output logic [1:0] o_mic_boost,
    output logic [5:0] o_left_pga_gain,
    output logic [5:0] o_right_pga_gain,
    output logic o_left_pga_mute,
    output logic o_right_pga_mute
);
    generate
        if (SW < 24 || SW > 30) begin : g_chk
            $error("sample width must be 24 to 30 bits");
        end
    endgenerate

    // shared control bits
    logic diff_reg;
    logic [1:0] boost_reg;
    logic alc_sel_reg;
    logic timeout_en_reg;
    logic invert_reg;
    logic hold_reg;
    logic [1:0] hpf_en_reg;
    logic smp_valid_reg;
    logic [`ARP_DATA_W-1:0] rdata_next;

    wire wr_en = i_ce & i_reg_wr;
    wire wr_path = wr_en & (i_reg_addr == `ARP_REG_PATH_CTRL);
    wire wr_level = wr_en & (i_reg_addr == `ARP_REG_LEVEL_CTRL);
    wire wr_add1 = wr_en & (i_reg_addr == `ARP_REG_ADD_CTRL1);
    wire wr_input = wr_en & (i_reg_addr == `ARP_REG_INPUT_PATH);
    wire upd_bit = i_reg_wdata[`ARP_BIT_UPDATE];
    wire [1:0] wr_pga;
    wire [1:0] wr_vol;
    wire [1:0] own_alc = {1'b0, alc_sel_reg};
    wire upd_pga = |wr_pga & upd_bit;
    wire upd_vol = |wr_vol & upd_bit;
    wire filt_valid_l;
    wire filt_valid_r;
    wire [1:0] filt_valid = {filt_valid_r, filt_valid_l};
    wire [1:0][SW-1:0] smp_in = {i_smp_right, i_smp_left};

    function automatic logic [15:0] vol_mant(input logic [3:0] m);
        // 0.5 dB steps inside one 6 dB span, unsigned q1.15
        unique case (m)
            4'h0: vol_mant = 16'h8000;
            4'h1: vol_mant = 16'h8796;
            4'h2: vol_mant = 16'h8F9E;
            4'h3: vol_mant = 16'h9821;
            4'h4: vol_mant = 16'hA124;
            4'h5: vol_mant = 16'hAAB1;
            4'h6: vol_mant = 16'hB4CE;
            4'h7: vol_mant = 16'hBF85;
            4'h8: vol_mant = 16'hCADE;
            4'h9: vol_mant = 16'hD6E3;
            4'hA: vol_mant = 16'hE39F;
            4'hB: vol_mant = 16'hF11C;
            default: vol_mant = 16'h0000;
        endcase
    endfunction : vol_mant

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : ch_g
            logic [5:0] pga_code_reg;
            logic pga_mute_reg;
            logic zc_en_reg;
            logic [7:0] vol_code_reg;
            logic [7:0] vol_reg;
            logic [SW-1:0] out_reg;
            logic signed [SW-1:0] filt_data;
            arp_gain_if gif ();

            assign wr_pga[ch] = wr_en & (i_reg_addr == (`ARP_REG_LEFT_PGA + 7'(ch)))
                                & ~own_alc[ch];
            assign wr_vol[ch] = wr_en & (i_reg_addr == (`ARP_REG_LEFT_ADC_VOL + 7'(ch)));
            wire zc_en_now = wr_pga[ch] ? i_reg_wdata[`ARP_BIT_ZC] : zc_en_reg;

            // the written channel takes the new code, the other its latch
            assign gif.req = upd_pga & ~own_alc[ch];
            assign gif.req_gain = wr_pga[ch] ? i_reg_wdata[`ARP_PGA_GAIN_MSB:0] : pga_code_reg;
            assign gif.req_mute = wr_pga[ch] ? i_reg_wdata[`ARP_BIT_MUTE] : pga_mute_reg;

            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    pga_code_reg <= `ARP_PGA_GAIN_RST;
                    pga_mute_reg <= `ARP_PGA_MUTE_RST;
                    zc_en_reg <= 1'b0;
                    vol_code_reg <= `ARP_ADC_VOL_RST;
                    vol_reg <= `ARP_ADC_VOL_RST;
                end else begin
                    if (wr_pga[ch]) begin
                        pga_code_reg <= i_reg_wdata[`ARP_PGA_GAIN_MSB:0];
                        pga_mute_reg <= i_reg_wdata[`ARP_BIT_MUTE];
                        zc_en_reg <= i_reg_wdata[`ARP_BIT_ZC];
                    end
                    if (wr_vol[ch]) begin
                        vol_code_reg <= i_reg_wdata[7:0];
                    end
                    if (upd_vol) begin
                        vol_reg <= wr_vol[ch] ? i_reg_wdata[7:0] : vol_code_reg;
                    end
                end
            end

            arp_zero_cross #(
                .TIMEOUT(ZC_TIMEOUT)
            ) u_zc (
                .i_core_clk(i_core_clk),
                .i_rst_n(i_rst_n),
                .i_ce(i_ce),
                .i_valid(i_smp_valid),
                .i_sign(smp_in[ch][SW-1]),
                .i_zc_en(zc_en_now),
                .i_to_en(timeout_en_reg),
                .gif(gif)
            );

            arp_dc_filter #(
                .SW(SW),
                .SHIFT(HPF_SHIFT)
            ) u_hpf (
                .i_core_clk(i_core_clk),
                .i_rst_n(i_rst_n),
                .i_ce(i_ce),
                .i_valid(i_smp_valid),
                .i_data(smp_in[ch]),
                .i_hpf_en(hpf_en_reg[ch]),
                .i_hold(hold_reg),
                .o_valid(),
                .o_data(filt_data)
            );

            // negation saturates so the most negative code cannot wrap
            wire signed [SW-1:0] max_v = {1'b0, {(SW-1){1'b1}}};
            wire signed [SW-1:0] min_v = {1'b1, {(SW-1){1'b0}}};
            wire signed [SW-1:0] pol = !invert_reg ? filt_data :
                                       (filt_data == min_v) ? max_v : -filt_data;
            // gain split into 6 dB spans and 0.5 dB steps; the span is a true
            // doubling, so each span runs about 0.02 dB wide of the ideal curve
            wire [8:0] vol_n = {1'b0, vol_reg} + `ARP_VOL_EXP_BIAS;
            wire [8:0] vol_q = vol_n / `ARP_VOL_STEPS_PER_6DB;
            wire [8:0] vol_r = vol_n % `ARP_VOL_STEPS_PER_6DB;
            wire [4:0] vol_e = vol_q[4:0];
            wire signed [16:0] mant = {1'b0, vol_mant(vol_r[3:0])};
            wire signed [SW+16:0] prod = pol * mant;
            wire signed [63:0] wide = {{(47-SW){prod[SW+16]}}, prod};
            wire signed [63:0] scaled = (wide <<< vol_e) >>> `ARP_VOL_FRAC_SHIFT;
            wire signed [63:0] max_w = {{(65-SW){1'b0}}, {(SW-1){1'b1}}};
            wire signed [63:0] min_w = {{(65-SW){1'b1}}, {(SW-1){1'b0}}};
            wire [SW-1:0] vol_out = (vol_reg == 8'h00) ? '0 :
                                    (scaled > max_w) ? max_v :
                                    (scaled < min_w) ? min_v : scaled[SW-1:0];

            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    out_reg <= '0;
                end else if (i_ce && filt_valid[ch]) begin
                    out_reg <= vol_out;
                end
            end
        end
    endgenerate

    assign filt_valid_l = ch_g[0].u_hpf.o_valid;
    assign filt_valid_r = ch_g[1].u_hpf.o_valid;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            diff_reg <= 1'b0;
            boost_reg <= `ARP_BOOST_RST;
            alc_sel_reg <= 1'b0;
            timeout_en_reg <= 1'b0;
            invert_reg <= 1'b0;
            hold_reg <= 1'b0;
            hpf_en_reg <= 2'h0;
        end else begin
            if (wr_input) begin
                diff_reg <= i_reg_wdata[`ARP_BIT_DIFF];
                boost_reg <= i_reg_wdata[`ARP_BOOST_MSB:`ARP_BOOST_LSB];
            end
            if (wr_level) begin
                alc_sel_reg <= i_reg_wdata[`ARP_BIT_ALC];
            end
            if (wr_add1) begin
                timeout_en_reg <= i_reg_wdata[`ARP_BIT_TIMEOUT];
            end
            if (wr_path) begin
                invert_reg <= i_reg_wdata[`ARP_BIT_INVERT];
                hold_reg <= i_reg_wdata[`ARP_BIT_HOLD];
                hpf_en_reg <= {i_reg_wdata[`ARP_BIT_HPF_R], i_reg_wdata[`ARP_BIT_HPF_L]};
            end
        end
    end

    // reads of the amplifier and volume registers show what is applied
    always_comb begin
        rdata_next = '0;
        unique case (i_reg_addr)
            `ARP_REG_LEFT_PGA:
                rdata_next = {1'b0, ch_g[0].gif.mute, ch_g[0].zc_en_reg, ch_g[0].gif.gain};
            `ARP_REG_RIGHT_PGA:
                rdata_next = {1'b0, ch_g[1].gif.mute, ch_g[1].zc_en_reg, ch_g[1].gif.gain};
            `ARP_REG_PATH_CTRL:
                rdata_next = {3'h0, invert_reg, hold_reg, 2'h0, hpf_en_reg};
            `ARP_REG_LEVEL_CTRL: rdata_next = {alc_sel_reg, 8'h00};
            `ARP_REG_LEFT_ADC_VOL: rdata_next = {1'b0, ch_g[0].vol_reg};
            `ARP_REG_RIGHT_ADC_VOL: rdata_next = {1'b0, ch_g[1].vol_reg};
            `ARP_REG_ADD_CTRL1: rdata_next = {8'h00, timeout_en_reg};
            `ARP_REG_INPUT_PATH: rdata_next = {diff_reg, 2'h0, boost_reg, 4'h0};
            default: rdata_next = '0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= '0;
            o_reg_rvalid <= 1'b0;
            smp_valid_reg <= 1'b0;
            o_diff_input_select <= 1'b0;
            o_mic_boost <= `ARP_BOOST_RST;
            o_left_pga_gain <= `ARP_PGA_GAIN_RST;
            o_right_pga_gain <= `ARP_PGA_GAIN_RST;
            o_left_pga_mute <= `ARP_PGA_MUTE_RST;
            o_right_pga_mute <= `ARP_PGA_MUTE_RST;
        end else if (i_ce) begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_next;
            end
            smp_valid_reg <= filt_valid_l;
            o_diff_input_select <= diff_reg;
            o_mic_boost <= boost_reg;
            o_left_pga_gain <= ch_g[0].gif.gain;
            o_right_pga_gain <= ch_g[1].gif.gain;
            o_left_pga_mute <= ch_g[0].gif.mute;
            o_right_pga_mute <= ch_g[1].gif.mute;
        end
    end

    assign o_smp_valid = smp_valid_reg;
    assign o_smp_left = ch_g[0].out_reg;
    assign o_smp_right = ch_g[1].out_reg;
endmodule : arp_record_ctrl

// ### arp_record_ctrl_sva.sv
// port assertions for the record path control
`timescale 1ns/100ps
`include "arp_defs.svh"
module arp_rec_sva (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic [`ARP_ADDR_W-1:0] i_reg_addr,
    input wire logic [`ARP_DATA_W-1:0] i_reg_wdata,
    input wire logic i_smp_valid,
    input wire logic o_smp_valid,
    input wire logic o_diff_input_select,
    input wire logic [1:0] o_mic_boost,
    input wire logic [5:0] o_left_pga_gain,
    input wire logic o_left_pga_mute,
    input wire logic o_right_pga_mute
);
    logic alc_reg;
    logic [2:0] path_reg;
    wire wr_go = i_ce && i_reg_wr;
    wire wr_left = wr_go && i_reg_addr == `ARP_REG_LEFT_PGA;
    wire wr_path = wr_go && i_reg_addr == `ARP_REG_INPUT_PATH;
    // shadow of written bits, so no check has to look inside the block
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            alc_reg <= 1'b0;
            path_reg <= 3'h0;
        end else if (wr_go && i_reg_addr == `ARP_REG_LEVEL_CTRL) begin
            alc_reg <= i_reg_wdata[8];
        end else if (wr_path) begin
            path_reg <= {i_reg_wdata[8], i_reg_wdata[5:4]};
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    property p_rst_vals; !$past(i_rst_n) |-> o_left_pga_mute && o_right_pga_mute
        && o_left_pga_gain == 6'h17; endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset outputs");
    property p_path; wr_path ##1 !wr_path |=> {o_diff_input_select, o_mic_boost} == path_reg;
    endproperty
    a_path: assert property (p_path) else $error("input path mismatch");
    property p_gain_now; wr_left && i_reg_wdata[8] && !i_reg_wdata[6] && !alc_reg ##1 !wr_go
        |=> o_left_pga_gain == $past(i_reg_wdata[5:0], 2); endproperty
    a_gain_now: assert property (p_gain_now) else $error("gain not applied");
    property p_gain_wait; wr_left && i_reg_wdata[8] && i_reg_wdata[6]
        ##1 (!i_smp_valid && !wr_go) [*3] |-> $stable(o_left_pga_gain); endproperty
    a_gain_wait: assert property (p_gain_wait) else $error("gain not deferred");
    property p_alc_lock; alc_reg && wr_left |=> $stable(o_left_pga_gain) [*3]; endproperty
    a_alc_lock: assert property (p_alc_lock) else $error("gain changed under alc");
    property p_mute_held; o_left_pga_mute && wr_left && !i_reg_wdata[8]
        |=> o_left_pga_mute [*2]; endproperty
    a_mute_held: assert property (p_mute_held) else $error("mute left early");
    property p_smp_lat; i_ce && i_smp_valid |-> ##2 o_smp_valid; endproperty
    a_smp_lat: assert property (p_smp_lat) else $error("sample lost");
    property p_smp_cause; o_smp_valid |-> $past(i_smp_valid, 2); endproperty
    a_smp_cause: assert property (p_smp_cause) else $error("stray sample");
    c_zc: cover property (wr_left && i_reg_wdata[6]);
    c_alc: cover property (alc_reg && wr_left);
    c_path: cover property (wr_path && i_reg_wdata[8]);
endmodule : arp_rec_sva
bind arp_record_ctrl arp_rec_sva sva_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_smp_valid(i_smp_valid), .o_smp_valid(o_smp_valid),
    .o_diff_input_select(o_diff_input_select), .o_mic_boost(o_mic_boost),
    .o_left_pga_gain(o_left_pga_gain), .o_left_pga_mute(o_left_pga_mute),
    .o_right_pga_mute(o_right_pga_mute));

// ### arp_zero_cross.sv
// per-channel amplifier gain release: immediate, on zero crossing, or on timeout
`timescale 1ns/100ps
`include "arp_defs.svh"
module arp_zero_cross #(
    parameter int TIMEOUT = `ARP_ZC_TIMEOUT_SMP
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_valid,
    input wire logic i_sign,
    input wire logic i_zc_en,
    input wire logic i_to_en,
    arp_gain_if.zc gif
);
    localparam int CW = $clog2(TIMEOUT + 1);

    generate
        if (TIMEOUT < 2) begin : g_chk
            $error("timeout must be at least two samples");
        end
    endgenerate

    arp_pkg::arp_zc_state_e state_reg, state_next;
    arp_pkg::arp_pga_gain_t pend_gain_reg, pend_gain_next;
    arp_pkg::arp_pga_gain_t gain_reg, gain_next;
    logic pend_mute_reg, pend_mute_next;
    logic mute_reg, mute_next;
    logic prev_sign_reg;
    logic [CW-1:0] cnt_reg, cnt_next;

    wire crossing = i_valid & (i_sign != prev_sign_reg);
    wire timed_out = i_to_en & i_valid & (cnt_reg == CW'(TIMEOUT - 1));

    assign gif.gain = gain_reg;
    assign gif.mute = mute_reg;

    always_comb begin
        state_next = state_reg;
        pend_gain_next = pend_gain_reg;
        pend_mute_next = pend_mute_reg;
        gain_next = gain_reg;
        mute_next = mute_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            arp_pkg::ARP_ZC_IDLE: begin
            end
            arp_pkg::ARP_ZC_WAIT: begin
                // a crossing of the input sign, the timeout or zero cross turned off releases the waiting change
                if (!i_zc_en || crossing || timed_out) begin
                    gain_next = pend_gain_reg;
                    mute_next = pend_mute_reg;
                    state_next = arp_pkg::ARP_ZC_IDLE;
                end else if (i_valid) begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
        endcase
        // a newer request replaces one still waiting
        if (gif.req) begin
            if (!i_zc_en) begin
                gain_next = gif.req_gain;
                mute_next = gif.req_mute;
                state_next = arp_pkg::ARP_ZC_IDLE;
            end else begin
                pend_gain_next = gif.req_gain;
                pend_mute_next = gif.req_mute;
                cnt_next = '0;
                state_next = arp_pkg::ARP_ZC_WAIT;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= arp_pkg::ARP_ZC_IDLE;
            pend_gain_reg <= `ARP_PGA_GAIN_RST;
            pend_mute_reg <= `ARP_PGA_MUTE_RST;
            gain_reg <= `ARP_PGA_GAIN_RST;
            mute_reg <= `ARP_PGA_MUTE_RST;
            cnt_reg <= '0;
            prev_sign_reg <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            pend_gain_reg <= pend_gain_next;
            pend_mute_reg <= pend_mute_next;
            gain_reg <= gain_next;
            mute_reg <= mute_next;
            cnt_reg <= cnt_next;
            if (i_valid) begin
                prev_sign_reg <= i_sign;
            end
        end
    end
endmodule : arp_zero_cross

// ### test_adc_record_path_control.sv
// self-checking bench for the record path control
`timescale 1ns/100ps
module test_adc_record_path_control;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sv = 1'b0;
    logic [23:0] sl = 24'h0;
    logic [23:0] sr = 24'h0;
    logic wr, rd, rv, ov, dif, lm, rm;
    logic [6:0] ad;
    logic [8:0] wd, rdat;
    logic [23:0] ol, orr, held;
    logic [1:0] bst;
    logic [5:0] lg, rg;
    int n_mismatch = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    arp_record_ctrl #(.ZC_TIMEOUT(4), .HPF_SHIFT(4)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_ce(1'b1), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(ad), .i_reg_wdata(wd),
        .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_smp_valid(sv), .i_smp_left(sl),
        .i_smp_right(sr), .o_smp_valid(ov), .o_smp_left(ol), .o_smp_right(orr),
        .o_diff_input_select(dif), .o_mic_boost(bst), .o_left_pga_gain(lg),
        .o_right_pga_gain(rg), .o_left_pga_mute(lm), .o_right_pga_mute(rm));
    arp_host host_u (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_wr(wr), .o_rd(rd),
        .o_addr(ad), .o_wdata(wd));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rdc(input logic [6:0] a, input logic [8:0] exp);
        logic [8:0] d;
        host_u.rd(a, d);
        chk(24'(d), 24'(exp));
    endtask : rdc
    task automatic smp(input logic [23:0] l, input logic [23:0] r);
        @(negedge clk);
        sv = 1'b1;
        sl = l;
        sr = r;
        @(negedge clk);
        sv = 1'b0;
        sl = ~l;
        sr = ~r;
        for (int k = 0; k < 6 && ov !== 1'b1; k++) @(negedge clk);
        chk(24'(ov), 24'h1);
    endtask : smp
    task automatic t_reset;
        rdc(7'h15, 9'h0C3);
        rdc(7'h00, 9'h097);
        rdc(7'h7F, 9'h000);
        chk({lm, rm, 16'h0, lg}, {2'b11, 16'h0, 6'h17});
        $display("test reset done");
    endtask : t_reset
    task automatic t_path;
        for (int b = 0; b < 4; b++) begin
            host_u.wr(7'h20, {b[0], 2'b00, b[1:0], 4'h0});
            repeat (2) @(negedge clk);
            chk({21'h0, dif, bst}, {21'h0, b[0], b[1:0]});
        end
        $display("test path done");
    endtask : t_path
    task automatic t_pga;
        host_u.wr(7'h01, 9'h02A);
        host_u.wr(7'h00, 9'h030);
        repeat (2) @(negedge clk);
        chk({17'h0, lm, lg}, {17'h0, 1'b1, 6'h17});
        host_u.wr(7'h00, 9'h130);
        repeat (2) @(negedge clk);
        chk({10'h0, lm, rm, lg, rg}, {10'h0, 2'b00, 6'h30, 6'h2A});
        $display("test pga done");
    endtask : t_pga
    task automatic t_zc;
        smp(24'h000100, 24'h000100);
        host_u.wr(7'h00, 9'h150);
        repeat (4) @(negedge clk);
        smp(24'h000200, 24'h000200);
        chk(24'(lg), 24'h30);
        smp(24'hFFFF00, 24'hFFFF00);
        chk(24'(lg), 24'h10);
        host_u.wr(7'h17, 9'h001);
        host_u.wr(7'h00, 9'h14C);
        repeat (3) smp(24'hFFFE00, 24'hFFFE00);
        chk(24'(lg), 24'h10);
        smp(24'hFFFE00, 24'hFFFE00);
        chk(24'(lg), 24'h0C);
        host_u.wr(7'h11, 9'h100);
        host_u.wr(7'h00, 9'h115);
        repeat (3) @(negedge clk);
        chk(24'(lg), 24'h0C);
        host_u.wr(7'h11, 9'h000);
        $display("test gain release done");
    endtask : t_zc
    task automatic t_dp;
        host_u.wr(7'h05, 9'h020);
        smp(24'h123456, 24'h7FFFF0);
        chk(ol, 24'hEDCBAA);
        chk(orr, 24'h800010);
        host_u.wr(7'h05, 9'h000);
        host_u.wr(7'h15, 9'h0CF);
        smp(24'h001000, 24'h001000);
        chk(ol, 24'h001000);
        rdc(7'h15, 9'h0C3);
        host_u.wr(7'h16, 9'h100);
        smp(24'h001000, 24'h001000);
        chk(ol, 24'h002000);
        chk(orr, 24'h000000);
        rdc(7'h15, 9'h0CF);
        host_u.wr(7'h16, 9'h0C3);
        host_u.wr(7'h15, 9'h1C3);
        host_u.wr(7'h05, 9'h001);
        repeat (20) smp(24'h010000, 24'h010000);
        chk(24'(ol < 24'h010000 && ol > 24'h0), 24'h1);
        chk(orr, 24'h010000);
        host_u.wr(7'h05, 9'h010);
        smp(24'h020000, 24'h020000);
        held = ol;
        smp(24'h030000, 24'h030000);
        chk(ol - held, 24'h010000);
        chk(24'(held != 24'h020000), 24'h1);
        host_u.wr(7'h05, 9'h000);
        smp(24'h020000, 24'h020000);
        chk(ol, 24'h020000);
        $display("test datapath done");
    endtask : t_dp
    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_path();
        t_pga();
        t_zc();
        t_dp();
        complete_run();
    end
    // about a hundred times what the tests need
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end
endmodule : test_adc_record_path_control
